// [include/pcm_pkg.sv]
// Constants, types and helpers for the PCI bus master controller.
// Assumes a 32-bit multiplexed bus on its own clock and a user side on clk.

`default_nettype none

package pcm_pkg;

    // ****************************************************************
    // Widths and limits
    // ****************************************************************
    localparam int AD_W       = 32;
    localparam int CBE_W      = 4;
    localparam int MAX_BEATS  = 4;
    localparam int BEAT_W     = 2;
    localparam int WAIT_LIMIT = 16;

    // ****************************************************************
    // Pin levels and parking values
    // ****************************************************************
    localparam logic              SIG_ON   = 1'b0;
    localparam logic              SIG_OFF  = 1'b1;
    localparam logic [AD_W-1:0]   AD_PARK  = 32'h0000_0000;
    localparam logic [CBE_W-1:0]  CBE_PARK = 4'h0;
    localparam logic              PAR_PARK = 1'b0;
    localparam logic [1:0]        DW_LOW   = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_DROP = 3'b011,
        ST_END  = 3'b100
    } pcm_state_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [CBE_W-1:0]                cmd;
        logic                            write;
        logic                            io;
        logic [AD_W-1:0]                 addr;
        logic [CBE_W-1:0]                be;
        logic [BEAT_W-1:0]               last;
        logic [MAX_BEATS-1:0][AD_W-1:0]  wdata;
    } pcm_req_t;

    typedef struct packed {
        logic [MAX_BEATS-1:0][AD_W-1:0]  rdata;
        logic [BEAT_W:0]                 done;
        logic                            abort;
        logic                            perr;
    } pcm_rsp_t;

    typedef struct packed {
        logic              frame_n;
        logic              irdy_n;
        logic [CBE_W-1:0]  cbe_n;
        logic [AD_W-1:0]   ad;
        logic              par;
    } pcm_pin_out_t;

    typedef struct packed {
        logic  frame;
        logic  irdy;
        logic  cbe;
        logic  ad;
        logic  par;
    } pcm_pin_oe_t;

    typedef struct packed {
        logic             trdy_n;
        logic [AD_W-1:0]  ad;
        logic             par;
    } pcm_pin_in_t;

    function automatic logic pcm_even_par(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
        return ^{ad, cbe};
    endfunction

endpackage

`default_nettype wire

// [core/pcm_sync.sv]
// Two-flop synchroniser for levels and toggles.
// Assumes d changes no faster than two destination clocks.
`timescale 1ns/1ps
`default_nettype none

module pcm_sync #(
    parameter int W = 1
) (
    input  wire logic [W-1:0] d,
    input  wire logic         clk,
    input  wire logic         rst_n,
    output logic      [W-1:0] q
);

    // First stage feeds the second stage only
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// [core/pcm_master.sv]
// PCI bus master and central resource: one transaction per user request.
// Assumes pci_clk runs free and a single target answers within the wait limit.
`timescale 1ns/1ps
`default_nettype none

module pcm_master #(
    parameter int WAIT_MAX = pcm_pkg::WAIT_LIMIT
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  pci_clk,
    input  wire logic                  req_valid,
    input  wire pcm_pkg::pcm_req_t     req,
    output logic                       req_ready,
    output logic                       resp_valid,
    output pcm_pkg::pcm_rsp_t          resp,
    output logic                       pci_rst_n,
    input  wire pcm_pkg::pcm_pin_in_t  pin_i,
    output pcm_pkg::pcm_pin_out_t      pin_o,
    output pcm_pkg::pcm_pin_oe_t       pin_oe
);
    import pcm_pkg::*;

    // ****************************************************************
    // User domain: request hold and response pickup
    // ****************************************************************
    logic      busy;
    logic      next_busy;
    logic      req_tgl;
    logic      next_req_tgl;
    logic      ack_seen;
    logic      next_ack_seen;
    logic      ack_sync;
    logic      next_req_ready;
    logic      next_resp_valid;
    pcm_req_t  hold;
    pcm_req_t  next_hold;
    pcm_rsp_t  next_resp;
    pcm_rsp_t  rsp;

    always_comb begin
        next_busy       = busy;
        next_req_tgl    = req_tgl;
        next_hold       = hold;
        next_ack_seen   = ack_seen;
        next_resp       = resp;
        next_resp_valid = 1'b0;
        if (!busy && req_valid && req_ready) begin
            next_hold    = req;
            next_req_tgl = !req_tgl;
            next_busy    = 1'b1;
        end
        // Link result is stable once its toggle has crossed
        if (ack_sync != ack_seen) begin
            next_ack_seen   = ack_sync;
            next_resp       = rsp;
            next_resp_valid = 1'b1;
            next_busy       = 1'b0;
        end
        next_req_ready = !next_busy;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy       <= 1'b0;
            req_tgl    <= 1'b0;
            hold       <= '0;
            ack_seen   <= 1'b0;
            resp       <= '0;
            resp_valid <= 1'b0;
            req_ready  <= 1'b0;
        end else begin
            busy       <= next_busy;
            req_tgl    <= next_req_tgl;
            hold       <= next_hold;
            ack_seen   <= next_ack_seen;
            resp       <= next_resp;
            resp_valid <= next_resp_valid;
            req_ready  <= next_req_ready;
        end
    end

    // ****************************************************************
    // Crossings
    // ****************************************************************
    logic link_rst_n;
    logic req_sync;
    logic ack_tgl;

    pcm_sync #(.W(1)) u_rst_sync (
        .d     (nrst),
        .clk   (pci_clk),
        .rst_n (1'b1),
        .q     (link_rst_n)
    );

    pcm_sync #(.W(1)) u_req_sync (
        .d     (req_tgl),
        .clk   (pci_clk),
        .rst_n (link_rst_n),
        .q     (req_sync)
    );

    pcm_sync #(.W(1)) u_ack_sync (
        .d     (ack_tgl),
        .clk   (clk),
        .rst_n (nrst),
        .q     (ack_sync)
    );

    // ****************************************************************
    // Link domain: bus sequencer
    // ****************************************************************
    pcm_state_t         state;
    pcm_state_t         next_state;
    logic [BEAT_W-1:0]  beat;
    logic [BEAT_W-1:0]  next_beat;
    logic [BEAT_W-1:0]  beat_nx;
    logic [4:0]         wait_cnt;
    logic [4:0]         next_wait;
    logic               req_seen;
    logic               next_req_seen;
    logic               next_ack_tgl;
    logic               chk_vld;
    logic               next_chk_vld;
    logic [AD_W-1:0]    chk_ad;
    logic [AD_W-1:0]    next_chk_ad;
    logic [CBE_W-1:0]   chk_cbe;
    logic [CBE_W-1:0]   next_chk_cbe;
    pcm_rsp_t           next_rsp;
    pcm_pin_out_t       next_pin_o;
    pcm_pin_oe_t        next_pin_oe;
    logic               new_req;

    assign new_req = (req_sync != req_seen);
    assign beat_nx = BEAT_W'(beat + 1'b1);

    always_comb begin
        next_state    = state;
        next_beat     = beat;
        next_wait     = wait_cnt;
        next_req_seen = req_seen;
        next_ack_tgl  = ack_tgl;
        next_rsp      = rsp;
        next_chk_vld  = 1'b0;
        next_chk_ad   = chk_ad;
        next_chk_cbe  = chk_cbe;
        next_pin_o    = pin_o;
        next_pin_oe   = pin_oe;
        next_pin_o.par  = pcm_even_par(pin_o.ad, pin_o.cbe_n);
        next_pin_oe.par = pin_oe.ad;
        // Read parity arrives one clock after each completed read phase
        if (chk_vld && (pin_i.par != pcm_even_par(chk_ad, chk_cbe))) begin
            next_rsp.perr = 1'b1;
        end
        unique case (state)
            ST_IDLE: begin
                // Parked low when idle; never answers as a target
                next_pin_o.ad    = AD_PARK;
                next_pin_o.cbe_n = CBE_PARK;
                next_pin_oe.ad   = 1'b1;
                next_pin_oe.cbe  = 1'b1;
                if (new_req) begin
                    next_req_seen       = req_sync;
                    next_pin_o.frame_n  = SIG_ON;
                    next_pin_oe.frame   = 1'b1;
                    next_pin_o.irdy_n   = SIG_OFF;
                    next_pin_oe.irdy    = 1'b1;
                    next_pin_o.ad       = hold.io ? hold.addr : {hold.addr[AD_W-1:2], DW_LOW};
                    next_pin_o.cbe_n    = hold.cmd;
                    next_rsp            = '0;
                    next_beat           = '0;
                    next_wait           = '0;
                    next_state          = ST_ADDR;
                end
            end
            ST_ADDR: begin
                next_pin_o.irdy_n  = SIG_ON;
                next_pin_o.cbe_n   = hold.be;
                next_pin_o.frame_n = (hold.last == '0) ? SIG_OFF : SIG_ON;
                if (hold.write) begin
                    next_pin_o.ad = hold.wdata[0];
                end else begin
                    next_pin_oe.ad = 1'b0;
                end
                next_state = ST_DATA;
            end
            ST_DATA: begin
                if (pin_i.trdy_n == SIG_ON) begin
                    next_wait     = '0;
                    next_beat     = beat_nx;
                    next_rsp.done = (BEAT_W + 1)'(rsp.done + 1'b1);
                    if (!hold.write) begin
                        next_rsp.rdata[beat] = pin_i.ad;
                        next_chk_vld         = 1'b1;
                        next_chk_ad          = pin_i.ad;
                        next_chk_cbe         = pin_o.cbe_n;
                    end
                    if (beat == hold.last) begin
                        next_pin_o.irdy_n  = SIG_OFF;
                        next_pin_o.frame_n = SIG_OFF;
                        next_pin_oe.ad     = 1'b0;
                        next_pin_oe.cbe    = 1'b0;
                        next_state         = ST_END;
                    end else begin
                        if (hold.write) begin
                            next_pin_o.ad = hold.wdata[beat_nx];
                        end
                        if (beat_nx == hold.last) begin
                            next_pin_o.frame_n = SIG_OFF;
                        end
                    end
                end else if (wait_cnt == 5'(WAIT_MAX - 1)) begin
                    // No target: drop FRAME# first so IRDY# can follow cleanly
                    next_pin_o.frame_n = SIG_OFF;
                    next_rsp.abort     = 1'b1;
                    next_state         = ST_DROP;
                end else begin
                    next_wait = 5'(wait_cnt + 1'b1);
                end
            end
            ST_DROP: begin
                next_pin_o.irdy_n = SIG_OFF;
                next_pin_oe.ad    = 1'b0;
                next_pin_oe.cbe   = 1'b0;
                next_state        = ST_END;
            end
            ST_END: begin
                // Controls were driven high last clock, now released
                next_pin_oe.frame = 1'b0;
                next_pin_oe.irdy  = 1'b0;
                next_ack_tgl      = !ack_tgl;
                next_state        = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pci_clk) begin
        if (!link_rst_n) begin
            state     <= ST_IDLE;
            beat      <= '0;
            wait_cnt  <= '0;
            req_seen  <= 1'b0;
            ack_tgl   <= 1'b0;
            rsp       <= '0;
            chk_vld   <= 1'b0;
            chk_ad    <= AD_PARK;
            chk_cbe   <= CBE_PARK;
            pin_o     <= '{frame_n: SIG_OFF, irdy_n: SIG_OFF, cbe_n: CBE_PARK, ad: AD_PARK, par: PAR_PARK};
            pin_oe    <= '{frame: 1'b0, irdy: 1'b0, cbe: 1'b1, ad: 1'b1, par: 1'b1};
            pci_rst_n <= SIG_ON;
        end else begin
            state     <= next_state;
            beat      <= next_beat;
            wait_cnt  <= next_wait;
            req_seen  <= next_req_seen;
            ack_tgl   <= next_ack_tgl;
            rsp       <= next_rsp;
            chk_vld   <= next_chk_vld;
            chk_ad    <= next_chk_ad;
            chk_cbe   <= next_chk_cbe;
            pin_o     <= next_pin_o;
            pin_oe    <= next_pin_oe;
            pci_rst_n <= SIG_OFF;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_addr_phase;
        state == ST_ADDR && pin_oe.frame && pin_o.frame_n == SIG_ON;
    endsequence

    sequence s_wait_phase;
        state == ST_DATA && pin_i.trdy_n == SIG_OFF && wait_cnt != 5'(WAIT_MAX - 1);
    endsequence

    sequence s_last_done;
        state == ST_DATA && pin_i.trdy_n == SIG_ON && beat == hold.last;
    endsequence

    property p_addr_pins;
        @(posedge pci_clk) disable iff (!link_rst_n)
        s_addr_phase |-> pin_oe.ad && pin_oe.cbe && pin_o.cbe_n == hold.cmd;
    endproperty
    a_addr_pins: assert property (p_addr_pins) else $error("address phase pins wrong");

    property p_addr_par;
        @(posedge pci_clk) disable iff (!link_rst_n)
        s_addr_phase |=> pin_oe.par && (pin_o.par == pcm_even_par($past(pin_o.ad), $past(pin_o.cbe_n)));
    endproperty
    a_addr_par: assert property (p_addr_par) else $error("address parity late or wrong");

    property p_par_even;
        @(posedge pci_clk) disable iff (!link_rst_n)
        pin_oe.par && $past(pin_oe.ad) |-> (^{pin_o.par, $past(pin_o.ad), $past(pin_o.cbe_n)}) == 1'b0;
    endproperty
    a_par_even: assert property (p_par_even) else $error("driven parity not even");

    property p_wr_data;
        @(posedge pci_clk) disable iff (!link_rst_n)
        s_addr_phase and hold.write |=> pin_o.irdy_n == SIG_ON && pin_oe.ad && pin_o.ad == hold.wdata[0];
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not valid with IRDY");

    property p_rd_turn;
        @(posedge pci_clk) disable iff (!link_rst_n)
        s_addr_phase and !hold.write |=> !pin_oe.ad && pin_oe.par ##1 !pin_oe.par;
    endproperty
    a_rd_turn: assert property (p_rd_turn) else $error("read turnaround drive wrong");

    property p_wait_stable;
        @(posedge pci_clk) disable iff (!link_rst_n)
        s_wait_phase |=> $stable(pin_o.ad) && $stable(pin_o.cbe_n) && pin_o.irdy_n == SIG_ON;
    endproperty
    a_wait_stable: assert property (p_wait_stable) else $error("data phase changed while waiting");

    property p_final_frame;
        @(posedge pci_clk) disable iff (!link_rst_n)
        state == ST_DATA && beat == hold.last |-> pin_o.frame_n == SIG_OFF;
    endproperty
    a_final_frame: assert property (p_final_frame) else $error("FRAME held in final phase");

    property p_last_end;
        @(posedge pci_clk) disable iff (!link_rst_n)
        s_last_done |=> pin_o.irdy_n == SIG_OFF && state == ST_END ##1 !pin_oe.irdy && !pin_oe.frame;
    endproperty
    a_last_end: assert property (p_last_end) else $error("transaction did not end after last phase");

    property p_ack;
        @(posedge pci_clk) disable iff (!link_rst_n)
        state == ST_END |=> ack_tgl != $past(ack_tgl) && state == ST_IDLE;
    endproperty
    a_ack: assert property (p_ack) else $error("completion not signalled");

endmodule

`default_nettype wire

// [dv/pcm_target_model.sv]
// Behavioural PCI target that faces pcm_master: one stored word per beat.
// Assumes the bench resolves AD wire levels and hands them in as ad_w; master PAR is read from pin_o.
`timescale 1ns/1ps
`default_nettype none

module pcm_target_model (
    input  wire logic                   pci_clk,
    input  wire logic                   rst_n,
    input  wire pcm_pkg::pcm_pin_out_t  pin_o,
    input  wire pcm_pkg::pcm_pin_oe_t   pin_oe,
    input  wire logic [31:0]            ad_w,
    input  wire logic [3:0]             wait_n,
    input  wire logic                   bad_par,
    input  wire logic                   no_trdy,
    output logic                        trdy_n,
    output logic [31:0]                 t_ad,
    output logic                        t_ad_oe,
    output logic                        t_par,
    output logic                        t_par_oe,
    output logic [31:0]                 cap_addr,
    output logic [3:0]                  cap_cmd,
    output logic [3:0]                  cap_be,
    output logic [3:0][31:0]            mem,
    output int                          par_bad
);
    import pcm_pkg::*;
    logic        active;
    logic [1:0]  beat;
    logic [3:0]  wcnt;
    logic        prev_drv;
    logic [35:0] prev_bus;

    // ******************************
    // Target sequencer
    // ******************************
    always_ff @(posedge pci_clk) begin
        prev_drv <= pin_oe.ad & pin_oe.cbe;
        prev_bus <= {pin_o.ad, pin_o.cbe_n};
        t_par    <= ^{t_ad, pin_o.cbe_n} ^ bad_par;
        t_par_oe <= t_ad_oe;
        if (!rst_n) begin
            active   <= 1'b0;
            trdy_n   <= 1'b1;
            t_ad_oe  <= 1'b0;
            t_par_oe <= 1'b0;
            par_bad  <= 0;
            mem      <= '0;
        end else begin
            // Master parity checked only where it drove the cycle before
            if (pin_oe.par && prev_drv && pin_o.par !== ^prev_bus) begin
                par_bad <= par_bad + 1;
            end
            if (!active) begin
                if (pin_oe.frame && !pin_o.frame_n) begin
                    active   <= 1'b1;
                    cap_addr <= ad_w;
                    cap_cmd  <= pin_o.cbe_n;
                    t_ad_oe  <= !pin_o.cbe_n[0];
                    t_ad     <= mem[0];
                    beat     <= 2'h0;
                    wcnt     <= 4'h0;
                    trdy_n   <= (wait_n != 4'h0) || no_trdy;
                end
            end else if (!pin_oe.irdy) begin
                // Master gave up: leave the bus
                active  <= 1'b0;
                trdy_n  <= 1'b1;
                t_ad_oe <= 1'b0;
            end else if (!pin_o.irdy_n && !trdy_n) begin
                cap_be <= pin_o.cbe_n;
                if (cap_cmd[0]) begin
                    mem[beat] <= ad_w;
                end
                beat   <= beat + 2'h1;
                t_ad   <= mem[beat + 2'h1];
                wcnt   <= 4'h0;
                trdy_n <= pin_o.frame_n || (wait_n != 4'h0) || no_trdy;
                if (pin_o.frame_n) begin
                    active  <= 1'b0;
                    t_ad_oe <= 1'b0;
                end
            end else if (trdy_n) begin
                wcnt <= wcnt + 4'h1;
                if (wcnt + 4'h1 >= wait_n && !no_trdy) begin
                    trdy_n <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for pcm_master against a behavioural target.
// Assumes the bench makes both clocks; the link clock is unrelated in phase.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pcm_pkg::*;
    logic               clk = 1'b0;
    logic               pci_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               req_valid = 1'b0;
    pcm_req_t           req = '0;
    logic               req_ready;
    logic               resp_valid;
    pcm_rsp_t           resp;
    logic               pci_rst_n;
    pcm_pin_in_t        pin_i;
    pcm_pin_out_t       pin_o;
    pcm_pin_oe_t        pin_oe;
    logic               trdy_n;
    logic [31:0]        t_ad;
    logic [31:0]        ad_w;
    logic               t_ad_oe;
    logic               t_par;
    logic               t_par_oe;
    logic [31:0]        cap_addr;
    logic [3:0]         cap_cmd;
    logic [3:0]         cap_be;
    logic [3:0][31:0]   mem;
    int                 par_bad;
    logic [3:0]         wait_n = 4'h0;
    logic               bad_par = 1'b0;
    logic               no_trdy = 1'b0;
    logic [3:0]         flt = 4'h0;
    logic [3:0][31:0]   wd = '0;
    int                 errors = 0;
    int                 n_tests = 0;
    int                 cyc = 0;

    always #12.5 clk = ~clk;
    always #6 pci_clk = ~pci_clk;

    // Released lines wander so a stale level never passes
    always @(posedge pci_clk) flt <= flt + 4'h1;
    assign ad_w  = pin_oe.ad ? pin_o.ad : (t_ad_oe ? t_ad : {8{flt}});
    assign pin_i = {trdy_n, ad_w, pin_oe.par ? pin_o.par : (t_par_oe ? t_par : flt[0])};

    pcm_master #(.WAIT_MAX(4)) i_pcm_master (
        .clk(clk), .nrst(nrst), .pci_clk(pci_clk), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .pci_rst_n(pci_rst_n),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));

    pcm_target_model i_pcm_target_model (
        .pci_clk(pci_clk), .rst_n(pci_rst_n), .pin_o(pin_o), .pin_oe(pin_oe), .ad_w(ad_w),
        .wait_n(wait_n), .bad_par(bad_par), .no_trdy(no_trdy), .trdy_n(trdy_n), .t_ad(t_ad),
        .t_ad_oe(t_ad_oe), .t_par(t_par), .t_par_oe(t_par_oe), .cap_addr(cap_addr),
        .cap_cmd(cap_cmd), .cap_be(cap_be), .mem(mem), .par_bad(par_bad));

    // ******************************
    // Shared tasks
    // ******************************
    task automatic results;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic xfer(input logic [3:0] cmd, input logic io, input logic [31:0] addr,
                        input logic [3:0] be, input logic [1:0] last);
        int n;
        @(posedge clk);
        req       <= '{cmd: cmd, write: cmd[0], io: io, addr: addr, be: be, last: last, wdata: wd};
        req_valid <= 1'b1;
        @(negedge clk);
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        for (n = 0; n < 400 && resp_valid !== 1'b1; n++) @(negedge clk);
        check(resp_valid, 1'b1, "no answer");
    endtask

    // ******************************
    // Scenarios
    // ******************************
    task automatic t_reset;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(pci_rst_n, 1'b0, "link reset out");
        check({pin_oe.frame, pin_oe.irdy}, 2'b00, "frame/irdy float");
        check({pin_oe.ad, pin_o.ad, pin_o.par}, 34'h2_0000_0000, "parking");
        check({req_ready, resp_valid}, 2'b00, "user idle");
        @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        check(pci_rst_n, 1'b1, "link reset released");
    endtask

    task automatic t_io_write;
        wd[0] = 32'hCAFE_0001;
        xfer(4'h3, 1'b1, 32'h0000_0103, 4'hE, 2'h0);
        check(cap_addr, 32'h0000_0103, "byte address");
        check(cap_cmd, 4'h3, "command");
        check(cap_be, 4'hE, "byte enables");
        check(mem[0], 32'hCAFE_0001, "io data");
        check({resp.done, resp.abort}, 4'h2, "io done");
    endtask

    task automatic t_burst_write;
        wd = {32'h4444_0004, 32'h3333_0003, 32'h2222_0002, 32'h1111_0001};
        xfer(4'h7, 1'b0, 32'h1234_567B, 4'h0, 2'h3);
        check(cap_addr, 32'h1234_5678, "dword address");
        for (int k = 0; k < 4; k++) check(mem[k], wd[k], "burst data");
        check({resp.done, resp.abort}, 4'h8, "burst done");
    endtask

    task automatic t_read_wait;
        wait_n <= 4'h2;
        xfer(4'h6, 1'b0, 32'h1234_5678, 4'h0, 2'h1);
        for (int k = 0; k < 2; k++) check(resp.rdata[k], wd[k], "read data");
        check({resp.done, resp.abort, resp.perr}, 5'h08, "read status");
        wait_n <= 4'h0;
    endtask

    task automatic t_bad_parity;
        bad_par <= 1'b1;
        xfer(4'h6, 1'b0, 32'h0000_0040, 4'h0, 2'h0);
        check(resp.perr, 1'b1, "parity error seen");
        bad_par <= 1'b0;
        xfer(4'h6, 1'b0, 32'h0000_0040, 4'h0, 2'h0);
        check(resp.perr, 1'b0, "parity clean again");
    endtask

    task automatic t_abort;
        no_trdy <= 1'b1;
        xfer(4'h6, 1'b0, 32'h0000_0080, 4'h0, 2'h2);
        check({resp.done, resp.abort}, 4'h1, "abort");
        no_trdy <= 1'b0;
        xfer(4'h7, 1'b0, 32'h0000_0080, 4'h0, 2'h0);
        check({resp.done, resp.abort}, 4'h2, "after abort");
        check(par_bad, 0, "master parity");
    endtask

    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    initial begin
        t_reset();
        t_io_write();
        t_burst_write();
        t_read_wait();
        t_bad_parity();
        t_abort();
        results();
    end
endmodule
`default_nettype wire
